// ### core/serial_port_pkg.sv
package serial_port_pkg;

	// Clock
	localparam int CLK_PERIOD_NS = 5;
	localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;

	// Bit timing
	localparam int OVERSAMPLE = 16;
	localparam int NUM_BAUDS = 8;
	localparam int BAUD_RATE [NUM_BAUDS] = '{19200, 9600, 4800, 2400, 1200, 600, 300, 150};
	localparam int DIV_W = 24;
	localparam logic [3:0] MID_SAMPLE = 4'h7;
	localparam logic [3:0] LAST_SAMPLE = 4'hF;
	localparam logic [2:0] BITS7_LAST = 3'h6;
	localparam logic [2:0] BITS8_LAST = 3'h7;

	// Register map
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_PARAMS = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_RXDATA = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_TXDATA = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_PROMPT = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h14;
	localparam int STAT_PERR_BIT = 1;
	localparam int STAT_FERR_BIT = 2;
	localparam int CTRL_DONE_BIT = 0;

	typedef enum logic [1:0] {
		PAR_NONE = 2'h0,
		PAR_EVEN = 2'h1,
		PAR_ODD = 2'h2
	} parity_t;

	typedef enum logic [1:0] {
		OWN_IDLE = 2'h0,
		OWN_SERIAL = 2'h1,
		OWN_PARALLEL = 2'h2
	} owner_t;

	typedef enum logic [2:0] {
		LN_IDLE = 3'h0,
		LN_START = 3'h1,
		LN_DATA = 3'h2,
		LN_PARITY = 3'h3,
		LN_STOP = 3'h4
	} line_state_t;

	typedef struct packed {
		logic word8;
		parity_t parity;
	} frame_cfg_t;

	// Bit 3 is the echo enable
	typedef struct packed {
		logic [2:0] baud;
		logic [1:0] rsvd;
		logic test_echo;
		logic prompt;
		logic echo;
		parity_t parity;
		logic word8;
	} serial_params_t;

	localparam int PARAMS_W = $bits(serial_params_t);

	typedef struct packed {
		logic [7:0] data;
		logic parity_err;
		logic frame_err;
	} rx_char_t;

	typedef struct packed {
		logic tx_busy;
		owner_t owner;
		logic tx_idle;
		logic frame_err;
		logic parity_err;
		logic rx_avail;
	} status_t;

	localparam serial_params_t PARAMS_RST = '{
		baud: 3'h0,
		rsvd: 2'h0,
		test_echo: 1'b0,
		prompt: 1'b1,
		echo: 1'b1,
		parity: PAR_EVEN,
		word8: 1'b0
	};
	localparam logic [6:0] PROMPT_RST = 7'h3E;

	// Terminal count of the oversample divider
	function automatic logic [DIV_W-1:0] baud_tc(input int clk_hz, input logic [2:0] sel);
		int d;
		d = clk_hz / (OVERSAMPLE * BAUD_RATE[sel]);
		if (d < 1)
			d = 1;
		return DIV_W'(d - 1);
	endfunction

endpackage

// ### core/serial_rx.sv
module serial_rx (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Line and timing
	input wire logic tick_i,
	input wire logic rxd_i,
	input serial_port_pkg::frame_cfg_t cfg_i,
	// Received character
	output logic valid_o,
	output serial_port_pkg::rx_char_t char_o
);
	typedef struct packed {
		serial_port_pkg::line_state_t st;
		logic [3:0] smp;
		logic [2:0] idx;
		logic [7:0] sh;
		logic valid;
		serial_port_pkg::rx_char_t ch;
	} rx_state_t;

	rx_state_t s;
	rx_state_t next_s;
	logic [2:0] last_idx;
	logic par_calc;

	always_comb
	begin
		next_s = s;
		next_s.valid = 1'b0;
		last_idx = cfg_i.word8 ? serial_port_pkg::BITS8_LAST : serial_port_pkg::BITS7_LAST;
		par_calc = ^s.sh;
		if (tick_i)
		begin
			next_s.smp = s.smp + 4'h1;
			case (s.st)
				serial_port_pkg::LN_IDLE:
					if (!rxd_i)
					begin
						next_s.st = serial_port_pkg::LN_START; // RL17
						next_s.smp = 4'h0;
					end
				serial_port_pkg::LN_START:
					if (s.smp == serial_port_pkg::MID_SAMPLE)
					begin
						// Realign on the start centre; a short glitch is dropped
						next_s.smp = 4'h0; // RL17
						next_s.idx = 3'h0;
						next_s.sh = 8'h00;
						next_s.ch.parity_err = 1'b0;
						next_s.st = rxd_i ? serial_port_pkg::LN_IDLE : serial_port_pkg::LN_DATA;
					end
				serial_port_pkg::LN_DATA:
					if (s.smp == serial_port_pkg::LAST_SAMPLE)
					begin
						next_s.sh[s.idx] = rxd_i; // RL1
						next_s.idx = s.idx + 3'h1;
						if (s.idx == last_idx)
						begin
							if (cfg_i.parity == serial_port_pkg::PAR_NONE) // RL2
								next_s.st = serial_port_pkg::LN_STOP;
							else
								next_s.st = serial_port_pkg::LN_PARITY;
						end
					end
				serial_port_pkg::LN_PARITY:
					if (s.smp == serial_port_pkg::LAST_SAMPLE)
					begin
						if (cfg_i.parity == serial_port_pkg::PAR_EVEN)
							next_s.ch.parity_err = rxd_i != par_calc; // RL18
						else
							next_s.ch.parity_err = rxd_i == par_calc; // RL18
						next_s.st = serial_port_pkg::LN_STOP;
					end
				serial_port_pkg::LN_STOP:
					if (s.smp == serial_port_pkg::LAST_SAMPLE)
					begin
						next_s.ch.frame_err = !rxd_i; // RL18
						next_s.ch.data = {1'b0, s.sh[6:0]}; // RL13
						next_s.valid = 1'b1;
						next_s.st = serial_port_pkg::LN_IDLE;
					end
				default:
					next_s.st = serial_port_pkg::LN_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			s <= '0;
		else
			s <= next_s;
	end

	assign valid_o = s.valid;
	assign char_o = s.ch;

endmodule // serial_rx

// ### core/serial_tx.sv
module serial_tx (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Timing and configuration
	input wire logic tick_i,
	input serial_port_pkg::frame_cfg_t cfg_i,
	// Character to send
	input wire logic start_i,
	input wire logic [7:0] data_i,
	// Line
	output logic txd_o,
	output logic busy_o
);
	typedef struct packed {
		serial_port_pkg::line_state_t st;
		logic [3:0] smp;
		logic [2:0] idx;
		logic [7:0] sh;
		logic txd;
	} tx_state_t;

	localparam tx_state_t TX_RST = '{
		st: serial_port_pkg::LN_IDLE,
		smp: 4'h0,
		idx: 3'h0,
		sh: 8'h00,
		txd: 1'b1
	};

	tx_state_t s;
	tx_state_t next_s;
	logic [2:0] last_idx;
	logic par_bit;

	always_comb
	begin
		next_s = s;
		last_idx = cfg_i.word8 ? serial_port_pkg::BITS8_LAST : serial_port_pkg::BITS7_LAST;
		par_bit = (cfg_i.parity == serial_port_pkg::PAR_ODD) ? ~^s.sh : ^s.sh;
		if (s.st == serial_port_pkg::LN_IDLE)
		begin
			if (start_i)
			begin
				next_s.sh = {1'b0, data_i[6:0]}; // RL13
				next_s.txd = 1'b0; // RL1
				next_s.smp = 4'h0;
				next_s.st = serial_port_pkg::LN_START;
			end
		end
		else if (tick_i)
		begin
			next_s.smp = s.smp + 4'h1;
			if (s.smp == serial_port_pkg::LAST_SAMPLE)
			begin
				case (s.st)
					serial_port_pkg::LN_START:
					begin
						next_s.idx = 3'h0;
						next_s.txd = s.sh[0];
						next_s.st = serial_port_pkg::LN_DATA;
					end
					serial_port_pkg::LN_DATA:
						if (s.idx == last_idx)
						begin
							if (cfg_i.parity == serial_port_pkg::PAR_NONE) // RL2
							begin
								next_s.txd = 1'b1;
								next_s.st = serial_port_pkg::LN_STOP;
							end
							else
							begin
								next_s.txd = par_bit; // RL2
								next_s.st = serial_port_pkg::LN_PARITY;
							end
						end
						else
						begin
							next_s.idx = s.idx + 3'h1;
							next_s.txd = s.sh[s.idx + 3'h1];
						end
					serial_port_pkg::LN_PARITY:
					begin
						next_s.txd = 1'b1;
						next_s.st = serial_port_pkg::LN_STOP;
					end
					default:
						next_s.st = serial_port_pkg::LN_IDLE; // RL3
				endcase
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			s <= TX_RST;
		else
			s <= next_s;
	end

	assign txd_o = s.txd;
	assign busy_o = s.st != serial_port_pkg::LN_IDLE;

endmodule // serial_tx

// ### core/serial_command_port.sv
// Function
// RL1 - Frame: start bit, 7 or 8 data bits, optional parity, one stop bit.
// RL2 - Parity selectable even, odd or none; none sends and expects no bit.
// RL3 - One stop bit always; word length, parity, baud set by software.
// RL4 - Selectable baud rates, the highest being 19,200 bits per second.
// RL5 - Commands and answers are 7-bit ASCII plus framing bits.
// RL6 - Serial and parallel commands never run at once; either follows completion.
// RL7 - By default a prompt character goes out whenever ready for a command.
// RL8 - By default every received character is echoed back; here none is echoed while the parallel port owns the command path.
// RL9 - Test echo copies parallel bus traffic out of the serial line.
// RL10 - Each command answers with data or changes a control setting.
// RL11 - Link uses only receive, transmit and ground.
// RL12 - Host matches baud, word length and parity to the device.
// RL13 - With 8-bit words the top bit is sent as zero, ignored on receive.
// RL14 - Echo off when parameter bit 3 is clear; bit 3 set at reset.
// RL15 - Reset configuration is even parity, 7 data bits, one stop bit.
// RL16 - Host waits for the echo before sending the next byte.
// RL17 - Receiver oversamples, resyncs on start edge, samples bit centres.
// RL18 - Receiver flags parity and stop bit errors without acting on them.
//
// Our own choices: the placing of the registers and the APB interface to the registers.
module serial_command_port #(
	parameter int CLK_FREQ_HZ = serial_port_pkg::CLK_HZ
) (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RSTN_I,
	// APB register port
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [serial_port_pkg::ADDR_W-1:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// Serial line
	input wire logic RXD_I,
	output logic TXD_O,
	// Parallel command port
	input wire logic PAR_CMD_REQ_I,
	output logic PAR_GRANT_O,
	input wire logic PAR_BYTE_VALID_I,
	input wire logic [7:0] PAR_BYTE_I
);
	typedef struct packed {
		logic [serial_port_pkg::DIV_W-1:0] div_cnt;
		logic tick;
		serial_port_pkg::serial_params_t params;
		logic [6:0] prompt_char;
		serial_port_pkg::owner_t owner;
		logic grant;
		logic rx_avail;
		logic [7:0] rx_data;
		logic perr;
		logic ferr;
		logic echo_pend;
		logic [7:0] echo_char;
		logic prompt_pend;
		logic resp_pend;
		logic [7:0] resp_char;
		logic mon_pend;
		logic [7:0] mon_char;
		logic tx_start;
		logic [7:0] tx_char;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} port_state_t;

	port_state_t s;
	port_state_t next_s;
	logic [1:0] rst_sync;
	logic rst_n;
	logic [serial_port_pkg::DIV_W-1:0] div_tc;
	serial_port_pkg::frame_cfg_t cfg;
	serial_port_pkg::status_t status;
	serial_port_pkg::serial_params_t wr_params;
	serial_port_pkg::rx_char_t rx_char;
	logic rx_valid;
	logic tx_busy;
	logic access;
	logic finish;
	logic mapped;
	logic done_cmd;

	// Reset release through two flops
	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end

	assign rst_n = rst_sync[1];

	serial_rx u_rx (
		.clk_i(CLK_I),
		.rst_n_i(rst_n),
		.tick_i(s.tick),
		.rxd_i(RXD_I),
		.cfg_i(cfg),
		.valid_o(rx_valid),
		.char_o(rx_char)
	);

	serial_tx u_tx (
		.clk_i(CLK_I),
		.rst_n_i(rst_n),
		.tick_i(s.tick),
		.cfg_i(cfg),
		.start_i(s.tx_start),
		.data_i(s.tx_char),
		.txd_o(TXD_O), // RL11
		.busy_o(tx_busy)
	);

	always_comb
	begin
		next_s = s;
		cfg.word8 = s.params.word8;
		cfg.parity = s.params.parity;
		div_tc = serial_port_pkg::baud_tc(CLK_FREQ_HZ, s.params.baud); // RL4
		access = PSEL_I && PENABLE_I;
		finish = access && s.pready;
		mapped = (PADDR_I == serial_port_pkg::ADDR_PARAMS)
			|| (PADDR_I == serial_port_pkg::ADDR_STATUS)
			|| (PADDR_I == serial_port_pkg::ADDR_RXDATA)
			|| (PADDR_I == serial_port_pkg::ADDR_TXDATA)
			|| (PADDR_I == serial_port_pkg::ADDR_PROMPT)
			|| (PADDR_I == serial_port_pkg::ADDR_CONTROL);
		status.tx_busy = tx_busy;
		status.owner = s.owner;
		status.tx_idle = !s.resp_pend;
		status.frame_err = s.ferr;
		status.parity_err = s.perr;
		status.rx_avail = s.rx_avail;
		wr_params = serial_port_pkg::serial_params_t'(PWDATA_I[serial_port_pkg::PARAMS_W-1:0]);
		// Command completion written this cycle
		done_cmd = finish && PWRITE_I
			&& PADDR_I == serial_port_pkg::ADDR_CONTROL
			&& PWDATA_I[serial_port_pkg::CTRL_DONE_BIT];

		// Oversample tick generator
		if (s.div_cnt >= div_tc)
		begin
			next_s.div_cnt = '0;
			next_s.tick = 1'b1; // RL17
		end
		else
		begin
			next_s.div_cnt = s.div_cnt + 1'b1;
			next_s.tick = 1'b0;
		end

		// APB: answer in the second access cycle
		next_s.pready = access && !s.pready;
		if (access && !s.pready)
		begin
			next_s.pslverr = !mapped;
			if (PWRITE_I)
				next_s.prdata = 32'h0000_0000;
			else if (PADDR_I == serial_port_pkg::ADDR_PARAMS)
				next_s.prdata = 32'(s.params);
			else if (PADDR_I == serial_port_pkg::ADDR_STATUS)
				next_s.prdata = 32'(status);
			else if (PADDR_I == serial_port_pkg::ADDR_RXDATA)
				next_s.prdata = 32'(s.rx_data);
			else if (PADDR_I == serial_port_pkg::ADDR_TXDATA)
				next_s.prdata = 32'(s.resp_char);
			else if (PADDR_I == serial_port_pkg::ADDR_PROMPT)
				next_s.prdata = 32'(s.prompt_char);
			else if (PADDR_I == serial_port_pkg::ADDR_CONTROL)
				next_s.prdata = 32'(s.grant);
			else
				next_s.prdata = 32'h0000_0000;
		end

		// Effects of a completed transfer
		if (finish && PWRITE_I)
		begin
			if (PADDR_I == serial_port_pkg::ADDR_PARAMS)
			begin
				next_s.params = wr_params; // RL3
				next_s.params.rsvd = 2'h0;
				if (wr_params.parity == serial_port_pkg::PAR_NONE
					|| wr_params.parity == serial_port_pkg::PAR_EVEN
					|| wr_params.parity == serial_port_pkg::PAR_ODD)
					next_s.params.parity = wr_params.parity; // RL2
				else
					next_s.params.parity = serial_port_pkg::PAR_NONE;
			end
			else if (PADDR_I == serial_port_pkg::ADDR_STATUS)
			begin
				if (PWDATA_I[serial_port_pkg::STAT_PERR_BIT])
					next_s.perr = 1'b0;
				if (PWDATA_I[serial_port_pkg::STAT_FERR_BIT])
					next_s.ferr = 1'b0;
			end
			else if (PADDR_I == serial_port_pkg::ADDR_TXDATA)
			begin
				next_s.resp_pend = 1'b1; // RL10
				next_s.resp_char = {1'b0, PWDATA_I[6:0]}; // RL5
			end
			else if (PADDR_I == serial_port_pkg::ADDR_PROMPT)
				next_s.prompt_char = PWDATA_I[6:0];
			else if (PADDR_I == serial_port_pkg::ADDR_CONTROL)
			begin
				if (PWDATA_I[serial_port_pkg::CTRL_DONE_BIT])
				begin
					// Command complete: free both ports and prompt
					next_s.owner = serial_port_pkg::OWN_IDLE; // RL6
					next_s.grant = 1'b0;
					next_s.prompt_pend = s.params.prompt; // RL7
				end
			end
		end
		if (finish && !PWRITE_I && PADDR_I == serial_port_pkg::ADDR_RXDATA)
			next_s.rx_avail = 1'b0;

		// Parallel port takes an idle command path
		if (s.owner == serial_port_pkg::OWN_IDLE && next_s.owner == serial_port_pkg::OWN_IDLE
			&& PAR_CMD_REQ_I && !rx_valid)
		begin
			next_s.owner = serial_port_pkg::OWN_PARALLEL; // RL6
			next_s.grant = 1'b1;
		end

		// Received character; sets win over clears
		if (rx_valid)
		begin
			// Built on the cleared value, so an error in a clear cycle stays
			next_s.perr = next_s.perr || rx_char.parity_err; // RL18
			next_s.ferr = next_s.ferr || rx_char.frame_err; // RL18
			if (s.owner != serial_port_pkg::OWN_PARALLEL)
			begin
				next_s.owner = serial_port_pkg::OWN_SERIAL; // RL6
				next_s.rx_avail = 1'b1;
				next_s.rx_data = rx_char.data;
				// One holder suffices while the host waits for each echo
				next_s.echo_pend = s.params.echo; // RL8 RL14 RL16
				next_s.echo_char = rx_char.data;
			end
		end

		// Monitor copy of parallel traffic
		if (PAR_BYTE_VALID_I && s.params.test_echo && s.owner == serial_port_pkg::OWN_PARALLEL)
		begin
			next_s.mon_pend = 1'b1; // RL9
			next_s.mon_char = {1'b0, PAR_BYTE_I[6:0]};
		end

		// Transmit arbitration: echo, prompt, response, monitor
		next_s.tx_start = 1'b0;
		if (!tx_busy && !s.tx_start)
		begin
			if (s.echo_pend)
			begin
				next_s.tx_start = 1'b1; // RL8
				next_s.tx_char = s.echo_char;
				next_s.echo_pend = rx_valid && next_s.echo_pend;
			end
			else if (s.prompt_pend)
			begin
				next_s.tx_start = 1'b1; // RL7
				next_s.tx_char = {1'b0, s.prompt_char};
				// A completion in the launch cycle queues the next prompt
				next_s.prompt_pend = done_cmd && s.params.prompt; // RL7
			end
			else if (s.resp_pend)
			begin
				next_s.tx_start = 1'b1; // RL10
				next_s.tx_char = s.resp_char;
				next_s.resp_pend = finish && PWRITE_I && PADDR_I == serial_port_pkg::ADDR_TXDATA;
			end
			else if (s.mon_pend)
			begin
				next_s.tx_start = 1'b1; // RL9
				next_s.tx_char = s.mon_char;
				next_s.mon_pend = PAR_BYTE_VALID_I && next_s.mon_pend;
			end
		end
	end

	always_ff @(posedge CLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s <= '0;
			s.params <= serial_port_pkg::PARAMS_RST; // RL14 RL15
			s.prompt_char <= serial_port_pkg::PROMPT_RST;
			s.prompt_pend <= 1'b1; // RL7
		end
		else
			s <= next_s;
	end

	assign PRDATA_O = s.prdata;
	assign PREADY_O = s.pready;
	assign PSLVERR_O = s.pslverr;
	assign PAR_GRANT_O = s.grant;

endmodule // serial_command_port

// ### verif/serial_command_port_sva.sv
module serial_command_port_chk #(
	parameter int CLK_FREQ_HZ = serial_port_pkg::CLK_HZ
) (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RSTN_I,
	// APB register port
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [serial_port_pkg::ADDR_W-1:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic PREADY_O,
	input wire logic PSLVERR_O,
	// Serial line and parallel port
	input wire logic RXD_I,
	input wire logic TXD_O,
	input wire logic PAR_CMD_REQ_I,
	input wire logic PAR_GRANT_O,
	input wire logic PAR_BYTE_VALID_I,
	input wire logic [7:0] PAR_BYTE_I
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TICK = CLK_FREQ_HZ / (serial_port_pkg::OVERSAMPLE * 19200);
	// A start-bit misalignment of one tick is allowed, so two ticks of slack
	localparam int MIN_RUN = 14 * TICK;
	int run;
	logic txd_q;
	logic mapped;
	logic done_wr;
	assign mapped = PADDR_I inside {serial_port_pkg::ADDR_PARAMS, serial_port_pkg::ADDR_STATUS,
		serial_port_pkg::ADDR_RXDATA, serial_port_pkg::ADDR_TXDATA,
		serial_port_pkg::ADDR_PROMPT, serial_port_pkg::ADDR_CONTROL};
	assign done_wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I
		&& PADDR_I == serial_port_pkg::ADDR_CONTROL && PWDATA_I[serial_port_pkg::CTRL_DONE_BIT];
	// Length of the present level on the transmit line
	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			run <= 65535;
			txd_q <= 1'b1;
		end
		else
		begin
			txd_q <= TXD_O;
			if (TXD_O != txd_q)
				run <= 1;
			else if (run < 65535)
				run <= run + 1;
		end
	end
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RSTN_I);
	chk_ready_wait: assert property ($rose(PSEL_I && PENABLE_I) |=> PREADY_O ##1 !PREADY_O)
		else $error("ready not one wait state");
	chk_ready_cause: assert property (PREADY_O |-> PSEL_I && PENABLE_I && $past(PENABLE_I))
		else $error("ready without access");
	chk_err_unmapped: assert property (PREADY_O && !mapped |-> PSLVERR_O && PRDATA_O == 32'h0)
		else $error("unmapped access not refused");
	chk_ok_mapped: assert property (PREADY_O && mapped |-> !PSLVERR_O)
		else $error("mapped access refused");
	chk_grant_cause: assert property ($rose(PAR_GRANT_O) |-> $past(PAR_CMD_REQ_I))
		else $error("grant without request");
	chk_grant_hold: assert property ($fell(PAR_GRANT_O) |-> $past(done_wr) || $past(done_wr, 2))
		else $error("grant dropped before done");
	chk_low_bit: assert property ($rose(TXD_O) |-> run >= MIN_RUN)
		else $error("low level shorter than a bit");
	chk_high_bit: assert property ($fell(TXD_O) |-> run >= MIN_RUN)
		else $error("high level shorter than a bit");
	chk_idle_reset: assert property ($rose(RSTN_I) |-> TXD_O && !PAR_GRANT_O ##1 TXD_O)
		else $error("line not idle after reset");
	cover property ($rose(PAR_GRANT_O));
	cover property (PREADY_O && PSLVERR_O);
	cover property ($fell(TXD_O) && PAR_GRANT_O);
endmodule // serial_command_port_chk

bind serial_command_port serial_command_port_chk #(.CLK_FREQ_HZ(CLK_FREQ_HZ)) i_chk (
	.CLK_I(CLK_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
	.PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
	.PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .RXD_I(RXD_I), .TXD_O(TXD_O),
	.PAR_CMD_REQ_I(PAR_CMD_REQ_I), .PAR_GRANT_O(PAR_GRANT_O),
	.PAR_BYTE_VALID_I(PAR_BYTE_VALID_I), .PAR_BYTE_I(PAR_BYTE_I)
);

// ### verif/host_term.sv
// Three-wire link: one line each way, ground implied
module host_term (
	// Clock
	input wire logic clk_i,
	// Line settings, kept equal to the device's
	input wire logic [15:0] bit_cyc_i,
	input wire logic word8_i,
	input serial_port_pkg::parity_t par_i,
	// Line
	input wire logic txd_i,
	output logic rxd_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial rxd_o = 1'b1;
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	function automatic logic par_bit(input logic [7:0] d);
		return (par_i == serial_port_pkg::PAR_ODD) ? ~^d : ^d;
	endfunction
	task automatic send(input logic [7:0] c, input logic bad);
		logic q[$];
		logic [7:0] m;
		m = word8_i ? c : {1'b0, c[6:0]};
		q.push_back(1'b0);
		for (int i = 0; i < (word8_i ? 8 : 7); i++)
			q.push_back(m[i]);
		if (par_i != serial_port_pkg::PAR_NONE)
			q.push_back(par_bit(m) ^ bad);
		q.push_back(1'b1);
		foreach (q[i])
		begin
			@(posedge clk_i);
			rxd_o <= q[i];
			wait_cyc(bit_cyc_i - 1);
		end
	endtask
	task automatic recv(output logic [7:0] c, output logic got, output logic ok);
		c = 8'h00;
		got = 1'b0;
		for (int n = 0; n < 40 * bit_cyc_i && !got; n++)
		begin
			@(posedge clk_i);
			got = !txd_i;
		end
		ok = got;
		if (!got)
			return;
		wait_cyc(bit_cyc_i / 2);
		ok = !txd_i;
		for (int i = 0; i < (word8_i ? 8 : 7); i++)
		begin
			wait_cyc(bit_cyc_i);
			c[i] = txd_i;
		end
		if (par_i != serial_port_pkg::PAR_NONE)
		begin
			wait_cyc(bit_cyc_i);
			ok = ok && txd_i == par_bit(c);
		end
		wait_cyc(bit_cyc_i);
		ok = ok && txd_i;
	endtask
endmodule // host_term

// ### verif/instrument_serial_command_port_tb.sv
module instrument_serial_command_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int FHZ = 3072000;
	localparam logic [31:0] CFG [4] = '{32'h019, 32'h01C, 32'h11B, 32'h018};
	localparam logic [7:0] CH [4] = '{8'hC1, 8'h5A, 8'h33, 8'h7F};
	logic clk, rstn, psel, penable, pwrite, pready, pslverr, rxd, txd, req, grant, bvalid;
	logic [7:0] paddr, pbyte;
	logic [31:0] pwdata, prdata, rdv;
	logic erv, word8;
	logic [15:0] bcyc;
	serial_port_pkg::parity_t par;
	int n_errors, compares;
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	serial_command_port #(.CLK_FREQ_HZ(FHZ)) i_dut (.CLK_I(clk), .RSTN_I(rstn),
		.PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.RXD_I(rxd), .TXD_O(txd), .PAR_CMD_REQ_I(req), .PAR_GRANT_O(grant),
		.PAR_BYTE_VALID_I(bvalid), .PAR_BYTE_I(pbyte));
	host_term i_host (.clk_i(clk), .bit_cyc_i(bcyc), .word8_i(word8), .par_i(par),
		.txd_i(txd), .rxd_o(rxd));
	task automatic wrap_up;
		$display("compares=%0d n_errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++)
		begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		if (n == 16)
		begin
			n_errors++;
			wrap_up();
		end
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rdv & mask, exp);
	endtask
	task automatic expect_rx(input logic [7:0] exp);
		logic [7:0] c;
		logic got, ok;
		i_host.recv(c, got, ok);
		check(32'(got), 32'h1);
		if (!got)
			wrap_up();
		check(32'(c), 32'(exp));
		check(32'(ok), 32'h1);
	endtask
	task automatic xfer(input logic [7:0] c, input logic [7:0] exp, input logic echo, input logic bad);
		logic [7:0] rc;
		logic got, ok;
		// The next byte goes only after this echo has been read
		fork
			i_host.send(c, bad);
			if (echo)
				expect_rx(exp);
			else
			begin
				i_host.recv(rc, got, ok);
				check(32'(got), 32'h0);
			end
		join
	endtask
	task automatic done;
		apb(1'b1, serial_port_pkg::ADDR_CONTROL, 32'h1);
		expect_rx(8'h3E);
		for (int n = 0; n < 64; n++)
		begin
			apb(1'b0, serial_port_pkg::ADDR_STATUS, 32'h0);
			if (rdv[6] === 1'b0)
				return;
		end
		n_errors++;
		wrap_up();
	endtask
	task automatic setcfg(input logic [31:0] p);
		apb(1'b1, serial_port_pkg::ADDR_PARAMS, p);
		word8 = p[0];
		par = serial_port_pkg::parity_t'(p[2:1]);
		bcyc = 16'(16 * (FHZ / (16 * serial_port_pkg::BAUD_RATE[p[10:8]])));
		rd(serial_port_pkg::ADDR_PARAMS, 32'h7FF, p);
	endtask
	initial
	begin
		{psel, penable, pwrite, req, bvalid, rstn, word8} = 7'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		pbyte = 8'h00;
		par = serial_port_pkg::PAR_EVEN;
		bcyc = 16'hA0;
		n_errors = 0;
		compares = 0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		expect_rx(8'h3E);
		rd(serial_port_pkg::ADDR_PARAMS, 32'hFFFFFFFF, 32'h1A);
		rd(serial_port_pkg::ADDR_PROMPT, 32'h7F, 32'h3E);
		apb(1'b0, 8'h20, 32'h0);
		check(rdv, 32'h0);
		check(32'(erv), 32'h1);
		xfer(8'h41, 8'h41, 1'b1, 1'b0);
		rd(serial_port_pkg::ADDR_RXDATA, 32'hFF, 32'h41);
		done();
		// Frame, parity and rate variants, top bit dropped in 8-bit words
		for (int i = 0; i < 4; i++)
		begin
			setcfg(CFG[i]);
			xfer(CH[i], CH[i] & 8'h7F, 1'b1, 1'b0);
			rd(serial_port_pkg::ADDR_RXDATA, 32'hFF, 32'(CH[i] & 8'h7F));
			done();
		end
		setcfg(32'h1A);
		xfer(8'h50, 8'h50, 1'b1, 1'b1);
		rd(serial_port_pkg::ADDR_STATUS, 32'h2, 32'h2);
		apb(1'b1, serial_port_pkg::ADDR_STATUS, 32'h2);
		rd(serial_port_pkg::ADDR_STATUS, 32'h2, 32'h0);
		done();
		setcfg(32'h12);
		xfer(8'h44, 8'h00, 1'b0, 1'b0);
		rd(serial_port_pkg::ADDR_RXDATA, 32'hFF, 32'h44);
		done();
		apb(1'b1, serial_port_pkg::ADDR_TXDATA, 32'hCF);
		expect_rx(8'h4F);
		setcfg(32'h3A);
		@(posedge clk);
		req <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		check(32'(grant), 32'h1);
		rd(serial_port_pkg::ADDR_CONTROL, 32'h1, 32'h1);
		@(posedge clk);
		req <= 1'b0;
		xfer(8'h45, 8'h00, 1'b0, 1'b0);
		fork
			begin
				@(posedge clk);
				bvalid <= 1'b1;
				pbyte <= 8'h52;
				@(posedge clk);
				bvalid <= 1'b0;
			end
			expect_rx(8'h52);
		join
		done();
		check(32'(grant), 32'h0);
		rd(serial_port_pkg::ADDR_CONTROL, 32'h1, 32'h0);
		xfer(8'h46, 8'h46, 1'b1, 1'b0);
		@(posedge clk);
		req <= 1'b1;
		repeat (3) @(posedge clk);
		check(32'(grant), 32'h0);
		req <= 1'b0;
		apb(1'b1, serial_port_pkg::ADDR_PROMPT, 32'hA3);
		rd(serial_port_pkg::ADDR_PROMPT, 32'hFFFFFFFF, 32'h23);
		apb(1'b1, serial_port_pkg::ADDR_PROMPT, 32'h3E);
		done();
		wrap_up();
	end
endmodule // instrument_serial_command_port_tb
